// ---- pkg/dfcd_pkg.sv ----
package dfcd_pkg;
  typedef logic [12:0] dfcd_freq_t;
  typedef logic [7:0]  dfcd_wid_t;
  typedef logic [13:0] dfcd_cur_t;
  typedef logic [6:0]  dfcd_dly_t;
  typedef logic [5:0]  dfcd_fcode_t;

  // Output function codes handled here
  typedef enum logic [5:0] {
    DFCD_F_FAGREE = 6'h02,
    DFCD_F_SAGREE = 6'h03,
    DFCD_F_DET1   = 6'h04,
    DFCD_F_DET2   = 6'h05,
    DFCD_F_CURAGR = 6'h0D,
    DFCD_F_CRANE  = 6'h27,
    DFCD_F_FOUT   = 6'h28,
    DFCD_F_DET3   = 6'h32,
    DFCD_F_DET4   = 6'h33,
    DFCD_F_DET5   = 6'h34,
    DFCD_F_DET6   = 6'h35
  } dfcd_fcode_e;

  // Current agree sequencer
  typedef enum logic [3:0] {
    DFCD_CA_IDLE = 4'h1,
    DFCD_CA_QUAL = 4'h2,
    DFCD_CA_ON   = 4'h4,
    DFCD_CA_REL  = 4'h8
  } dfcd_ca_e;

  // Live drive quantities, all on the control clock
  typedef struct packed {
    dfcd_freq_t freq_out;
    dfcd_freq_t freq_ref;
    dfcd_cur_t  cur_out;
    logic       accel;
    logic       decel;
    logic       out_active;
  } dfcd_drv_s;
endpackage

// ---- pkg/dfcd_regs.svh ----
`ifndef DFCD_REGS_SVH
`define DFCD_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define DFCD_OFS_LVL1    6'h00
`define DFCD_OFS_WID1    6'h04
`define DFCD_OFS_LVL2    6'h08
`define DFCD_OFS_WID2    6'h0C
`define DFCD_OFS_LVL3    6'h10
`define DFCD_OFS_WID3    6'h14
`define DFCD_OFS_FSEL    6'h18
`define DFCD_OFS_CURLVL  6'h1C
`define DFCD_OFS_CURDLY  6'h20
`define DFCD_OFS_STATUS  6'h24
// ----------------------------------------------------------------
// Field positions of the function select register
// ----------------------------------------------------------------
`define DFCD_FSEL_R1_LSB 0
`define DFCD_FSEL_R2_LSB 8
`define DFCD_FSEL_PH_LSB 16
// ----------------------------------------------------------------
// Ranges and reset values (0.1 Hz, 0.1 A, 0.1 s units)
// ----------------------------------------------------------------
`define DFCD_LVL_MAX     13'h1766
`define DFCD_WID_MIN     8'h01
`define DFCD_WID_MAX     8'hFF
`define DFCD_CUR_MIN     14'h0001
`define DFCD_CUR_MAX     14'h270F
`define DFCD_DLY_MIN     7'h01
`define DFCD_DLY_MAX     7'h64
`define DFCD_RST_LVL     13'h0000
`define DFCD_RST_WID     8'h01
`define DFCD_RST_CUR     14'h0001
`define DFCD_RST_DLY     7'h01
`define DFCD_RST_FSEL    6'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DFCD_CLK_NS      20
`define DFCD_T_TENTH_NS  100000000
`define DFCD_T_REL_MS    100
`endif

// ---- verif/dfcd_assertions.sv ----
`include "dfcd_regs.svh"

// ----------------------------------------------------------------
// Port checks of the bus handshake and the detect outputs
// ----------------------------------------------------------------
module dfcd_checker
  import dfcd_pkg::*;
#(
  parameter int TENTH_CYC = 10,
  parameter int REL_CYC   = 8
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Drive side and terminals
  input wire dfcd_drv_s   drv,
  input wire logic        relay_one_terminals,
  input wire logic        relay_two_terminals,
  input wire logic        photo_coupler_terminal
);
  dfcd_freq_t  lvl1_r;
  dfcd_wid_t   wid1_r;
  dfcd_cur_t   cur_r;
  dfcd_dly_t   dly_r;
  logic [21:0] fsel_r;
  int          above_r;
  wire logic       wr_done = write && !waitrequest;
  wire logic [5:0] r1 = fsel_r[5:0];
  wire logic [5:0] r2 = fsel_r[13:8];
  wire logic [5:0] ph = fsel_r[21:16];

  // Shadow of the settings; no clamping, so only in-range writes may feed the checks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lvl1_r <= 13'h0000;
      wid1_r <= 8'h01;
      cur_r <= 14'h0001;
      dly_r <= 7'h01;
      fsel_r <= 22'h000000;
      above_r <= 0;
    end else begin
      if (wr_done && address == `DFCD_OFS_LVL1) lvl1_r <= writedata[12:0];
      if (wr_done && address == `DFCD_OFS_WID1) wid1_r <= writedata[7:0];
      if (wr_done && address == `DFCD_OFS_CURLVL) cur_r <= writedata[13:0];
      if (wr_done && address == `DFCD_OFS_CURDLY) dly_r <= writedata[6:0];
      if (wr_done && address == `DFCD_OFS_FSEL) fsel_r <= writedata[21:0];
      above_r <= (drv.cur_out > cur_r) ? above_r + 1 : 0;
    end
  end

  bus_answer_a: assert property (@(posedge clock) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest) else $error("access not answered");
  bus_single_a: assert property (@(posedge clock) disable iff (rst)
    !waitrequest |=> waitrequest) else $error("waitrequest low too long");
  fout_follow_a: assert property (@(posedge clock) disable iff (rst)
    ph == 6'h28 && $past(ph) == 6'h28 |-> photo_coupler_terminal == $past(drv.out_active))
    else $error("frequency output does not follow the drive");
  idle_code_a: assert property (@(posedge clock) disable iff (rst)
    ph == 6'h00 && $past(ph) == 6'h00 |-> !photo_coupler_terminal)
    else $error("unused terminal closed");
  cur_r2_off_a: assert property (@(posedge clock) disable iff (rst)
    r2 == 6'h0D && $past(r2) == 6'h0D |-> !relay_two_terminals)
    else $error("current agree active on relay two");
  det_set_a: assert property (@(posedge clock) disable iff (rst)
    r1 == 6'h04 && $past(r1) == 6'h04 && $past(drv.freq_out, 2) > lvl1_r + wid1_r
    |-> relay_one_terminals) else $error("detection not set above upper threshold");
  det_clr_a: assert property (@(posedge clock) disable iff (rst)
    r1 == 6'h04 && $past(r1) == 6'h04 && $past(drv.freq_out, 2) < lvl1_r
    |-> !relay_one_terminals) else $error("detection not cleared below level");
  ca_hold_a: assert property (@(posedge clock) disable iff (rst)
    $rose(relay_one_terminals) && r1 == 6'h0D |-> relay_one_terminals [*8])
    else $error("current agree released early");
  ca_qual_a: assert property (@(posedge clock) disable iff (rst)
    $rose(relay_one_terminals) && r1 == 6'h0D |-> above_r >= dly_r * TENTH_CYC)
    else $error("current agree on before qualification");
endmodule

bind dfcd_top dfcd_checker #(.TENTH_CYC(TENTH_CYC), .REL_CYC(REL_CYC)) chk_i (
  .clock, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .drv,
  .relay_one_terminals, .relay_two_terminals, .photo_coupler_terminal);

// ---- verif/dfcd_load.sv ----
// ----------------------------------------------------------------
// Relay and photo-coupler load on the three terminals
// ----------------------------------------------------------------
module dfcd_load (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Coil or diode drive
  input wire logic [2:0] coil,
  // Contact state seen by the machine
  output logic     [2:0] contact
);
  timeunit 1ns;
  timeprecision 1ns;

  // Contacts follow one cycle late; real pickup is slower, nothing here relies on it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      contact <= 3'h0;
    end else begin
      contact <= coil;
    end
  end
endmodule

// ---- verif/dfcd_top_tb.sv ----
`include "dfcd_regs.svh"

module dfcd_top_tb
  import dfcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic        waitrequest;
  dfcd_drv_s   drv = '0;
  logic        relay_one_terminals;
  logic        relay_two_terminals;
  logic        photo_coupler_terminal;
  logic [2:0]  contact;
  int          num_errors = 0;
  int          checks_done = 0;
  int          rv[9] = '{0, 1, 0, 1, 0, 1, 0, 1, 1};
  int          ca[8] = '{0, 4, 12, 28, 28, 32, 32, 16};
  int          cw[8] = '{8191, 0, 255, 16383, 0, 127, 0, 5990};
  int          ce[8] = '{5990, 1, 255, 9999, 1, 100, 1, 5990};
  int          fs[4] = '{32'h00030504, 32'h00023332, 32'h00283534, 32'h00000D27};
  int          co[6] = '{0, 1, 0, -1, 0, 1};

  // Short counts keep qualification and release within a few dozen cycles
  dfcd_top #(.TENTH_CYC(10), .REL_CYC(8)) uut (
    .clock, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .drv,
    .relay_one_terminals, .relay_two_terminals, .photo_coupler_terminal);
  dfcd_load load_i (.clock, .rst,
    .coil({photo_coupler_terminal, relay_two_terminals, relay_one_terminals}), .contact);

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Expected photo-coupler level for the selection under test
  function automatic logic exp_photo(input int c, input int f, input int r,
                                     input logic [2:0] m, input int l0, input int w0);
    case (c)
      0: return (f - l0 <= w0) && (l0 - f <= w0);
      1: return m[0] && (f - r <= w0) && (r - f <= w0);
      2: return m[0];
      default: return 1'b0;
    endcase
  endfunction

  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) chk(1'b0, 1'b1);
    @(posedge clock);
  endtask

  task automatic wr(input logic [5:0] a, input int d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask

  // Drive side values, then let the two-edge output lag and the load's extra edge settle
  task automatic put(input int f, input int r, input logic [2:0] m);
    drv.freq_out <= 13'(f);
    drv.freq_ref <= 13'(r);
    {drv.accel, drv.decel, drv.out_active} <= m;
    repeat (4) @(posedge clock);
  endtask

  task automatic wait_r1(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (relay_one_terminals !== v && n < 60);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Test sequence is well under 2000 cycles; the limit leaves a wide margin
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    int l[3], w[3], f, r, t, n, c, s;
    logic [2:0]  m;
    logic        h, ep, g;
    logic [31:0] q;
    void'($urandom(42));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (n = 0; n < 9; n++) begin
      rd(6'(4 * n), q);
      chk(q, rv[n]);
    end
    wr(6'h28, 32'h0000ABCD);
    rd(6'h28, q);
    chk(q, 32'h00000000);
    $display("done: reset values");
    for (n = 0; n < 8; n++) begin
      wr(6'(ca[n]), cw[n]);
      rd(6'(ca[n]), q);
      chk(q, ce[n]);
    end
    $display("done: setting ranges");
    for (s = 0; s < 3; s++) begin
      l[s] = 300 + $urandom % 5000;
      w[s] = 1 + $urandom % 255;
      wr(6'(8 * s), l[s]);
      wr(6'(8 * s + 4), w[s]);
    end
    // Each selection: threshold corners first, then random drive values
    for (c = 0; c < 4; c++) begin
      s = (c == 3) ? 0 : c;
      t = l[s] + w[s];
      wr(`DFCD_OFS_FSEL, fs[c]);
      put(0, 0, 3'h2);
      h = 1'b0;
      for (n = 0; n < 30; n++) begin
        if (n < 6) begin
          f = t + co[n] - ((n == 2 || n == 3) ? w[s] : 0);
          r = f + w[0];
          m = 3'h7;
        end else begin
          f = l[s] - 30 + $urandom % (w[s] + 60);
          r = f + w[0] - 3 + $urandom % 7;
          m = $urandom % 8;
        end
        put(f, r, m);
        if ((c != 3 || m[2]) && f > t) h = 1'b1;
        else if ((c != 3 || m[1]) && f < l[s]) h = 1'b0;
        ep = exp_photo(c, f, r, m, l[0], w[0]);
        g = (c == 3) ? 1'b0 : !h;
        chk(relay_one_terminals, h);
        chk(relay_two_terminals, g);
        chk(photo_coupler_terminal, ep);
        chk(contact, {ep, g, h});
      end
      // Status shows the held terminals and the live run flag
      rd(`DFCD_OFS_STATUS, q);
      chk(q[13:9], {ep, g, h, 1'b0, m[0]});
    end
    $display("done: frequency detection");
    wr(`DFCD_OFS_FSEL, 32'h0000000D);
    wr(`DFCD_OFS_CURLVL, 32'h00000064);
    wr(`DFCD_OFS_CURDLY, 32'h00000002);
    drv.cur_out <= 14'h00C8;
    repeat (12) @(posedge clock);
    drv.cur_out <= 14'h0032;
    repeat (20) @(posedge clock);
    chk(relay_one_terminals, 1'b0);
    drv.cur_out <= 14'h0065;
    wait_r1(1'b1, n);
    chk(n >= 20 && n <= 25, 1'b1);
    drv.cur_out <= 14'h0064;
    wait_r1(1'b0, n);
    chk(n >= 8 && n <= 12, 1'b1);
    $display("done: current agree");
    print_verdict();
  end
endmodule

// ---- verilog/dfcd_top.sv ----
// Added by the designer: the register offsets and the Avalon-MM register port.
`include "dfcd_regs.svh"

// Function
// - Detection levels limited to 0.0-599.0 Hz
// - Detection widths limited to 0.1-25.5 Hz
// - Codes 2-5 use level/width one
// - Code 2: frequency within width of reference while drive outputs frequency
// - Code 3: frequency within width of level
// - Code 4: on above L+W, off below L
// - Code 5: complement hysteresis of code 4
// - Code 50: code 4 with set two
// - Code 51: code 5 with set two
// - Code 52: code 4 with set three
// - Code 53: code 5 with set three
// - Code 39: on above L+W while accelerating
// - Code 39: off below L while decelerating
// - Code 40: closed while drive outputs frequency
// - Current level and delay limited to ranges
// - Code 13 on relay one: current above level
// - Current agree release delayed 100 ms
// - Current agree on after qualification delay
module dfcd_top
  import dfcd_pkg::*;
#(
  parameter int TENTH_CYC = `DFCD_T_TENTH_NS / `DFCD_CLK_NS,
  parameter int REL_CYC   = (`DFCD_T_REL_MS * 1000000) / `DFCD_CLK_NS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Drive quantities
  input  wire dfcd_drv_s   drv,
  // Output terminals, high closes the contact
  output logic             relay_one_terminals,
  output logic             relay_two_terminals,
  output logic             photo_coupler_terminal
);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Clamp a written value into the legal setting range
  function automatic logic [15:0] clamp(input logic [31:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < {16'h0000, lo}) begin
      return lo;
    end else if (v > {16'h0000, hi}) begin
      return hi;
    end else begin
      return v[15:0];
    end
  endfunction

  // Map a function code onto the detection flags
  function automatic logic sel_out(input dfcd_fcode_t c,
                                   input logic [10:0] f,
                                   input logic        cur_ok);
    case (c)
      DFCD_F_FAGREE: sel_out = f[0];
      DFCD_F_SAGREE: sel_out = f[1];
      DFCD_F_DET1:   sel_out = f[2];
      DFCD_F_DET2:   sel_out = f[3];
      DFCD_F_DET3:   sel_out = f[4];
      DFCD_F_DET4:   sel_out = f[5];
      DFCD_F_DET5:   sel_out = f[6];
      DFCD_F_DET6:   sel_out = f[7];
      DFCD_F_CRANE:  sel_out = f[8];
      DFCD_F_FOUT:   sel_out = f[9];
      DFCD_F_CURAGR: sel_out = f[10] & cur_ok;
      default:       sel_out = 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Settings
  // --------------------------------------------------------------
  dfcd_freq_t  lvl_r [3];
  dfcd_wid_t   wid_r [3];
  dfcd_fcode_t fsel_r1_r;
  dfcd_fcode_t fsel_r2_r;
  dfcd_fcode_t fsel_ph_r;
  dfcd_cur_t   cur_lvl_r;
  dfcd_dly_t   cur_dly_r;
  logic        waitrequest_r;
  logic [31:0] readdata_r;
  logic [31:0] rd_nxt;

  // Bus decode
  wire         req      = read | write;
  wire         wr_take  = write & ~waitrequest_r;
  wire [15:0]  wd_lvl   = clamp(writedata, {3'h0, 13'h0000}, {3'h0, `DFCD_LVL_MAX});
  wire [15:0]  wd_wid   = clamp(writedata, {8'h00, `DFCD_WID_MIN},
                                {8'h00, `DFCD_WID_MAX});
  wire [15:0]  wd_cur   = clamp(writedata, {2'h0, `DFCD_CUR_MIN},
                                {2'h0, `DFCD_CUR_MAX});
  wire [15:0]  wd_dly   = clamp(writedata, {9'h000, `DFCD_DLY_MIN},
                                {9'h000, `DFCD_DLY_MAX});

  // --------------------------------------------------------------
  // Level / width pairs, one per detection set
  // --------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_set
      localparam logic [5:0] OL = `DFCD_OFS_LVL1 + 6'(8 * gi);
      localparam logic [5:0] OW = `DFCD_OFS_WID1 + 6'(8 * gi);
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          lvl_r[gi] <= `DFCD_RST_LVL;
          wid_r[gi] <= `DFCD_RST_WID;
        end else if (wr_take) begin
          if (address == OL) lvl_r[gi] <= wd_lvl[12:0];
          if (address == OW) wid_r[gi] <= wd_wid[7:0];
        end
      end
    end
  endgenerate

  // Function select and current agree settings
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fsel_r1_r <= `DFCD_RST_FSEL;
      fsel_r2_r <= `DFCD_RST_FSEL;
      fsel_ph_r <= `DFCD_RST_FSEL;
      cur_lvl_r <= `DFCD_RST_CUR;
      cur_dly_r <= `DFCD_RST_DLY;
    end else if (wr_take) begin
      if (address == `DFCD_OFS_FSEL) begin
        fsel_r1_r <= writedata[`DFCD_FSEL_R1_LSB +: 6];
        fsel_r2_r <= writedata[`DFCD_FSEL_R2_LSB +: 6];
        fsel_ph_r <= writedata[`DFCD_FSEL_PH_LSB +: 6];
      end
      if (address == `DFCD_OFS_CURLVL) cur_lvl_r <= wd_cur[13:0];
      if (address == `DFCD_OFS_CURDLY) cur_dly_r <= wd_dly[6:0];
    end
  end

  // --------------------------------------------------------------
  // Frequency comparisons
  // --------------------------------------------------------------
  logic [13:0] hi_th [3];
  logic        above [3];
  logic        below [3];
  logic        det_r [3];
  logic        crane_r;

  // Upper threshold is level plus width; band between holds state
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      assign hi_th[gi] = {1'b0, lvl_r[gi]} + {6'h00, wid_r[gi]};
      assign above[gi] = {1'b0, drv.freq_out} > hi_th[gi];
      assign below[gi] = drv.freq_out < lvl_r[gi];
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          det_r[gi] <= 1'b0;
        end else if (above[gi]) begin
          det_r[gi] <= 1'b1;
        end else if (below[gi]) begin
          det_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Crane variant only moves with the ramp direction
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crane_r <= 1'b0;
    end else if (above[0] && drv.accel) begin
      crane_r <= 1'b1;
    end else if (below[0] && drv.decel) begin
      crane_r <= 1'b0;
    end
  end

  // Agree windows, widened so a zero reference still agrees at zero
  wire [13:0] f_w   = {1'b0, drv.freq_out} + {6'h00, wid_r[0]};
  wire [13:0] ref_w = {1'b0, drv.freq_ref} + {6'h00, wid_r[0]};
  wire        f_agree = drv.out_active && (f_w >= {1'b0, drv.freq_ref})
                        && ({1'b0, drv.freq_out} <= ref_w);
  wire        s_agree = (f_w >= {1'b0, lvl_r[0]})
                        && ({1'b0, drv.freq_out} <= hi_th[0]);

  // --------------------------------------------------------------
  // Current agree sequencer
  // --------------------------------------------------------------
  dfcd_ca_e    ca_r;
  dfcd_ca_e    ca_nxt;
  logic [22:0] cyc_r;
  logic [22:0] cyc_nxt;
  logic [6:0]  ten_r;
  logic [6:0]  ten_nxt;

  wire cur_above = drv.cur_out > cur_lvl_r;
  wire tick_ten  = cyc_r == 23'(TENTH_CYC - 1);
  wire tick_rel  = cyc_r == 23'(REL_CYC - 1);

  // Qualify for the delay, then hold through the release time
  always_comb begin
    ca_nxt  = ca_r;
    cyc_nxt = cyc_r + 23'h000001;
    ten_nxt = ten_r;
    case (ca_r)
      DFCD_CA_IDLE: begin
        cyc_nxt = 23'h000000;
        ten_nxt = 7'h00;
        if (cur_above) ca_nxt = DFCD_CA_QUAL;
      end
      DFCD_CA_QUAL: begin
        if (!cur_above) begin
          ca_nxt = DFCD_CA_IDLE;
        end else if (ten_r >= cur_dly_r) begin
          ca_nxt = DFCD_CA_ON;
        end else if (tick_ten) begin
          cyc_nxt = 23'h000000;
          ten_nxt = ten_r + 7'h01;
        end
      end
      DFCD_CA_ON: begin
        cyc_nxt = 23'h000000;
        if (!cur_above) ca_nxt = DFCD_CA_REL;
      end
      DFCD_CA_REL: begin
        if (cur_above) begin
          ca_nxt = DFCD_CA_ON;
        end else if (tick_rel) begin
          ca_nxt = DFCD_CA_IDLE;
        end
      end
      default: begin
        ca_nxt = DFCD_CA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ca_r  <= DFCD_CA_IDLE;
      cyc_r <= 23'h000000;
      ten_r <= 7'h00;
    end else begin
      ca_r  <= ca_nxt;
      cyc_r <= cyc_nxt;
      ten_r <= ten_nxt;
    end
  end

  wire cur_agree = (ca_r == DFCD_CA_ON) || (ca_r == DFCD_CA_REL);

  // --------------------------------------------------------------
  // Output selection
  // --------------------------------------------------------------
  // Codes 5, 51 and 53 are the complement of their rising partner
  wire [10:0] flags = {cur_agree, drv.out_active, crane_r,
                       ~det_r[2], det_r[2], ~det_r[1], det_r[1],
                       ~det_r[0], det_r[0], s_agree, f_agree};
  wire r1_nxt = sel_out(fsel_r1_r, flags, 1'b1);
  wire r2_nxt = sel_out(fsel_r2_r, flags, 1'b0);
  wire ph_nxt = sel_out(fsel_ph_r, flags, 1'b0);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      relay_one_terminals    <= 1'b0;
      relay_two_terminals    <= 1'b0;
      photo_coupler_terminal <= 1'b0;
    end else begin
      relay_one_terminals    <= r1_nxt;
      relay_two_terminals    <= r2_nxt;
      photo_coupler_terminal <= ph_nxt;
    end
  end

  // --------------------------------------------------------------
  // Register read back
  // --------------------------------------------------------------
  // Unmapped addresses read zero and ignore writes
  always_comb begin
    case (address)
      `DFCD_OFS_LVL1:   rd_nxt = {19'h00000, lvl_r[0]};
      `DFCD_OFS_WID1:   rd_nxt = {24'h000000, wid_r[0]};
      `DFCD_OFS_LVL2:   rd_nxt = {19'h00000, lvl_r[1]};
      `DFCD_OFS_WID2:   rd_nxt = {24'h000000, wid_r[1]};
      `DFCD_OFS_LVL3:   rd_nxt = {19'h00000, lvl_r[2]};
      `DFCD_OFS_WID3:   rd_nxt = {24'h000000, wid_r[2]};
      `DFCD_OFS_FSEL:   rd_nxt = {10'h000, fsel_ph_r, 2'h0, fsel_r2_r,
                                  2'h0, fsel_r1_r};
      `DFCD_OFS_CURLVL: rd_nxt = {18'h00000, cur_lvl_r};
      `DFCD_OFS_CURDLY: rd_nxt = {25'h0000000, cur_dly_r};
      `DFCD_OFS_STATUS: rd_nxt = {18'h00000, photo_coupler_terminal,
                                  relay_two_terminals, relay_one_terminals,
                                  flags};
      default:          rd_nxt = 32'h00000000;
    endcase
  end

  // One wait cycle per access keeps read data registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
      readdata_r    <= 32'h00000000;
    end else begin
      waitrequest_r <= ~(req & waitrequest_r);
      if (read & waitrequest_r) readdata_r <= rd_nxt;
    end
  end

  assign waitrequest = waitrequest_r;
  assign readdata    = readdata_r;

endmodule
